/* File: verilog/cbu_map.svh */
// Opcode encodings, field positions and reset values for the conditional branch unit.
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH
`define CBU_OP_CC_GT      16'hC381
`define CBU_OP_CC_LE      16'hC380
`define CBU_OP_CC_LT      16'hC384
`define CBU_OP_CC_NE      16'hC383
`define CBU_OP_CC_EQ_DEF  16'hC382
`define CBU_OP_CC_GE_DEF  16'hC385
`define CBU_OP_CF_CLR     16'hC3C5
`define CBU_OP_CF_SET_DEF 16'hC3C4
`define CBU_FLT_PREFIX    7'h10
`define CBU_FLT_GT        8'h51
`define CBU_FLT_GE        8'h55
`define CBU_FLT_NE        8'h53
`define CBU_FLT_EQ        8'h52
`define CBU_FLT_LE_DEF    8'h50
`define CBU_FLT_LT_DEF    8'h54
`define CBU_HRD_PREFIX    6'h08
`define CBU_HRD_LOW       7'h64
`define CBU_PFX7_HI       15
`define CBU_PFX7_LO       9
`define CBU_FSEL_BIT      8
`define CBU_LOW8_HI       7
`define CBU_LOW8_LO       0
`define CBU_PFX6_HI       15
`define CBU_PFX6_LO       10
`define CBU_REG_HI        9
`define CBU_REG_LO        7
`define CBU_LOW7_HI       6
`define CBU_LOW7_LO       0
`define CBU_HALF_HI       31
`define CBU_HALF_LO       16
`define CBU_CC_RESET      2'h0
`define CBU_WORD_RESET    16'h0000
`define CBU_HALF_ONE      16'h0001
`endif

/* File: verilog/cbu_pkg.sv */
// Types shared by the conditional branch unit.
package cbu_pkg;
  // Condition code summary of the last result.
  typedef enum logic [1:0] {
    CBU_CC_ZERO = 2'h0,
    CBU_CC_POS  = 2'h1,
    CBU_CC_NEG  = 2'h2
  } cbu_cc_e;
  // Decoded branch kind.
  typedef enum logic [3:0] {
    CBU_K_NONE  = 4'h0,
    CBU_K_CC_GT = 4'h1,
    CBU_K_CC_LE = 4'h2,
    CBU_K_CC_LT = 4'h3,
    CBU_K_CC_NE = 4'h4,
    CBU_K_CC_EQ = 4'h5,
    CBU_K_CC_GE = 4'h6,
    CBU_K_CF_CL = 4'h7,
    CBU_K_CF_ST = 4'h8,
    CBU_K_F_GT  = 4'h9,
    CBU_K_F_GE  = 4'hA,
    CBU_K_F_NE  = 4'hB,
    CBU_K_F_EQ  = 4'hC,
    CBU_K_F_LE  = 4'hD,
    CBU_K_F_LT  = 4'hE,
    CBU_K_HRD   = 4'hF
  } cbu_kind_e;
  // One-hot control states.
  typedef enum logic [2:0] {
    CBU_S_IDLE = 3'b001,
    CBU_S_TGT  = 3'b010,
    CBU_S_EXEC = 3'b100
  } cbu_state_e;
endpackage : cbu_pkg

/* File: verilog/cbu_decode.sv */
// Opcode decoder mapping a first instruction word to a branch kind.
`timescale 1ns/1ps
`default_nettype none
`include "cbu_map.svh"
module cbu_decode #(
  parameter logic [15:0] OP_CC_EQ  = `CBU_OP_CC_EQ_DEF,
  parameter logic [15:0] OP_CC_GE  = `CBU_OP_CC_GE_DEF,
  parameter logic [15:0] OP_CF_SET = `CBU_OP_CF_SET_DEF,
  parameter logic [7:0]  FLT_LE    = `CBU_FLT_LE_DEF,
  parameter logic [7:0]  FLT_LT    = `CBU_FLT_LT_DEF
) (
  // Opcode word.
  input  wire logic [15:0]        i_op,
  // Decoded kind.
  output var  cbu_pkg::cbu_kind_e o_kind
);
  import cbu_pkg::*;
  logic       flt_pfx;
  logic [7:0] low8;
  // Field extraction.
  assign flt_pfx = (i_op[`CBU_PFX7_HI:`CBU_PFX7_LO] == `CBU_FLT_PREFIX);
  assign low8    = i_op[`CBU_LOW8_HI:`CBU_LOW8_LO];
  // Full-word compare first, then the floating and half register groups.
  always_comb begin
    o_kind = CBU_K_NONE;
    if (i_op == `CBU_OP_CC_GT) o_kind = CBU_K_CC_GT;
    else if (i_op == `CBU_OP_CC_LE) o_kind = CBU_K_CC_LE;
    else if (i_op == `CBU_OP_CC_LT) o_kind = CBU_K_CC_LT;
    else if (i_op == `CBU_OP_CC_NE) o_kind = CBU_K_CC_NE;
    else if (i_op == OP_CC_EQ) o_kind = CBU_K_CC_EQ;
    else if (i_op == OP_CC_GE) o_kind = CBU_K_CC_GE;
    else if (i_op == `CBU_OP_CF_CLR) o_kind = CBU_K_CF_CL;
    else if (i_op == OP_CF_SET) o_kind = CBU_K_CF_ST;
    else if (flt_pfx && low8 == `CBU_FLT_GT) o_kind = CBU_K_F_GT;
    else if (flt_pfx && low8 == `CBU_FLT_GE) o_kind = CBU_K_F_GE;
    else if (flt_pfx && low8 == `CBU_FLT_NE) o_kind = CBU_K_F_NE;
    else if (flt_pfx && low8 == `CBU_FLT_EQ) o_kind = CBU_K_F_EQ;
    else if (flt_pfx && low8 == FLT_LE) o_kind = CBU_K_F_LE;
    else if (flt_pfx && low8 == FLT_LT) o_kind = CBU_K_F_LT;
    else if (i_op[`CBU_PFX6_HI:`CBU_PFX6_LO] == `CBU_HRD_PREFIX &&
             i_op[`CBU_LOW7_HI:`CBU_LOW7_LO] == `CBU_HRD_LOW) begin
      o_kind = CBU_K_HRD;
    end
  end
endmodule : cbu_decode
`default_nettype wire

/* File: verilog/cbu_cond.sv */
// Branch condition evaluator for one kind against flags and a sign/zero view.
`timescale 1ns/1ps
`default_nettype none
module cbu_cond (
  // Decoded kind and operand summaries.
  input  wire cbu_pkg::cbu_kind_e i_kind,
  input  wire cbu_pkg::cbu_cc_e   i_cc,
  input  wire logic               i_cflag,
  input  wire logic               i_fzero,
  input  wire logic               i_fneg,
  input  wire logic               i_hnz,
  // Branch decision.
  output logic                    o_take
);
  import cbu_pkg::*;
  // Each kind picks its own test; unknown kinds never branch.
  always_comb begin
    case (i_kind)
      CBU_K_CC_GT: o_take = (i_cc == CBU_CC_POS);
      CBU_K_CC_LE: o_take = (i_cc != CBU_CC_POS);
      CBU_K_CC_LT: o_take = (i_cc == CBU_CC_NEG);
      CBU_K_CC_NE: o_take = (i_cc != CBU_CC_ZERO);
      CBU_K_CC_EQ: o_take = (i_cc == CBU_CC_ZERO);
      CBU_K_CC_GE: o_take = (i_cc != CBU_CC_NEG);
      CBU_K_CF_CL: o_take = !i_cflag;
      CBU_K_CF_ST: o_take = i_cflag;
      CBU_K_F_GT:  o_take = !i_fzero && !i_fneg;
      CBU_K_F_GE:  o_take = !i_fneg;
      CBU_K_F_NE:  o_take = !i_fzero;
      CBU_K_F_EQ:  o_take = i_fzero;
      CBU_K_F_LE:  o_take = i_fzero || i_fneg;
      CBU_K_F_LT:  o_take = i_fneg;
      CBU_K_HRD:   o_take = i_hnz;
      default:     o_take = 1'b0;
    endcase
  end
endmodule : cbu_cond
`default_nettype wire

/* File: verilog/cbu_branch_unit.sv */
// Conditional branch unit: decode, target capture and branch decision.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cbu_map.svh"
// What this block does
// - Opcode C381 branches when condition codes say greater than zero.
// - Opcode C380 branches when condition codes say zero or negative.
// - Opcode C384 branches when condition codes say negative.
// - Opcode C383 branches when condition codes say nonzero.
// - A condition-code equal branch is taken only on zero.
// - A condition-code greater-or-equal branch is taken on zero or positive.
// - Opcode C3C5 branches when exception carry flag is clear.
// - Companion opcode branches when exception carry flag is set.
// - Code and carry-flag branches leave carry-out, carry flag, codes alone.
// - Taken branch loads 16-bit in-segment target; untaken continues onward.
// - Floating branches start 0010000, then a bit selecting the accumulator.
// - Floating branches set codes from the compare; carry bits stay.
// - Floating low field 51 branches when accumulator is positive.
// - Floating low field 55 branches when accumulator is zero or positive.
// - Floating low field 53 branches when accumulator is nonzero.
// - Floating low field 52 branches when accumulator is zero.
// - Floating less-or-equal branches on zero or negative.
// - Floating less-than branches only on negative.
// - Half register decrement writes back and branches if result nonzero.
// - Half register decrement keeps carry flag, carry-out and codes.
// - Half register is bits one to sixteen, the upper half.
module cbu_branch_unit
  import cbu_pkg::*;
#(
  parameter int          PC_W      = 16,
  parameter logic [15:0] OP_CC_EQ  = `CBU_OP_CC_EQ_DEF,
  parameter logic [15:0] OP_CC_GE  = `CBU_OP_CC_GE_DEF,
  parameter logic [15:0] OP_CF_SET = `CBU_OP_CF_SET_DEF,
  parameter logic [7:0]  FLT_LE    = `CBU_FLT_LE_DEF,
  parameter logic [7:0]  FLT_LT    = `CBU_FLT_LT_DEF
) (
  // Clock and reset.
  input  wire  logic              I_CLK,
  input  wire  logic              I_SRST,
  // Instruction word stream from fetch.
  input  wire  logic              I_WORD_VALID,
  input  wire  logic [15:0]       I_WORD,
  input  wire  logic [PC_W-1:0]   I_PC,
  // Processor state inputs.
  input  wire  cbu_pkg::cbu_cc_e  I_CC,
  input  wire  logic              I_CARRY_FLAG,
  input  wire  logic              I_CARRY_OUT,
  input  wire  logic              I_FAC0_ZERO,
  input  wire  logic              I_FAC0_NEG,
  input  wire  logic              I_FAC1_ZERO,
  input  wire  logic              I_FAC1_NEG,
  // General register read port.
  output logic [2:0]              O_REG_SEL,
  input  wire  logic [31:0]       I_REG_DATA,
  // Recognition and completion.
  output logic                    O_CLAIM,
  output logic                    O_DONE,
  output logic                    O_TAKEN,
  output logic [PC_W-1:0]         O_NEXT_PC,
  // Flag and register write-back.
  output logic                    O_CC_WE,
  output cbu_pkg::cbu_cc_e        O_CC,
  output logic                    O_CARRY_FLAG,
  output logic                    O_CARRY_OUT,
  output logic                    O_REG_WE,
  output logic [31:0]             O_REG_WDATA
);
  // Only a 16-bit in-segment word address is produced, so other widths are refused.
  if (PC_W != 16) begin : g_bad_pc_w
    $error("cbu_branch_unit: PC_W must be 16");
  end

  typedef struct packed {
    cbu_state_e      st;
    cbu_kind_e       kind;
    logic [15:0]     op;
    logic [PC_W-1:0] pc;
    logic            done;
    logic            taken;
    logic [PC_W-1:0] npc;
    logic            cc_we;
    cbu_cc_e         cc;
    logic            cflag;
    logic            cout;
    logic            reg_we;
    logic [31:0]     wdata;
  } cbu_state_s;

  cbu_state_s r_r;
  cbu_state_s r_nxt;

  cbu_kind_e   dec_kind;
  logic        take;
  logic        fsel;
  logic        fzero;
  logic        fneg;
  logic [15:0] half_dec;
  logic        is_flt;

  cbu_decode #(
    .OP_CC_EQ  (OP_CC_EQ),
    .OP_CC_GE  (OP_CC_GE),
    .OP_CF_SET (OP_CF_SET),
    .FLT_LE    (FLT_LE),
    .FLT_LT    (FLT_LT)
  ) u_dec (
    .i_op   (I_WORD),
    .o_kind (dec_kind)
  );

  // Operand views for the held instruction.
  assign fsel     = r_r.op[`CBU_FSEL_BIT];
  assign fzero    = fsel ? I_FAC1_ZERO : I_FAC0_ZERO;
  assign fneg     = fsel ? I_FAC1_NEG : I_FAC0_NEG;
  assign half_dec = I_REG_DATA[`CBU_HALF_HI:`CBU_HALF_LO] - `CBU_HALF_ONE;
  assign is_flt   = (r_r.kind >= CBU_K_F_GT) && (r_r.kind <= CBU_K_F_LT);
  assign O_REG_SEL = r_r.op[`CBU_REG_HI:`CBU_REG_LO];

  cbu_cond u_cond (
    .i_kind  (r_r.kind),
    .i_cc    (I_CC),
    .i_cflag (I_CARRY_FLAG),
    .i_fzero (fzero),
    .i_fneg  (fneg),
    .i_hnz   (half_dec != `CBU_WORD_RESET),
    .o_take  (take)
  );

  // Claim is combinational so fetch can route the next word to this block.
  assign O_CLAIM = I_WORD_VALID && (r_r.st == CBU_S_IDLE) && (dec_kind != CBU_K_NONE);

  // Sequencer: opcode word, then target word, then one execute cycle.
  always_comb begin
    r_nxt        = r_r;
    r_nxt.done   = 1'b0;
    r_nxt.cc_we  = 1'b0;
    r_nxt.reg_we = 1'b0;
    case (r_r.st)
      CBU_S_IDLE: begin
        if (O_CLAIM) begin
          r_nxt.op   = I_WORD;
          r_nxt.kind = dec_kind;
          r_nxt.st   = CBU_S_TGT;
        end
      end
      CBU_S_TGT: begin
        // The target is held before the program counter is touched.
        if (I_WORD_VALID) begin
          r_nxt.pc = I_WORD;
          r_nxt.st = CBU_S_EXEC;
        end
      end
      CBU_S_EXEC: begin
        r_nxt.done  = 1'b1;
        r_nxt.taken = take;
        // Untaken falls past both words, which fetch has already consumed.
        r_nxt.npc   = take ? r_r.pc : I_PC;
        // Carry bits are always passed through unchanged.
        r_nxt.cflag = I_CARRY_FLAG;
        r_nxt.cout  = I_CARRY_OUT;
        r_nxt.cc    = I_CC;
        if (is_flt) begin
          r_nxt.cc_we = 1'b1;
          r_nxt.cc    = fzero ? CBU_CC_ZERO : (fneg ? CBU_CC_NEG : CBU_CC_POS);
        end
        if (r_r.kind == CBU_K_HRD) begin
          r_nxt.reg_we = 1'b1;
          r_nxt.wdata  = {half_dec, I_REG_DATA[`CBU_HALF_LO-1:0]};
        end
        r_nxt.st = CBU_S_IDLE;
      end
      default: r_nxt.st = CBU_S_IDLE;
    endcase
  end

  // State register with synchronous reset.
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      r_r       <= '0;
      r_r.st    <= CBU_S_IDLE;
      r_r.kind  <= CBU_K_NONE;
      r_r.cc    <= cbu_cc_e'(`CBU_CC_RESET);
    end else begin
      r_r <= r_nxt;
    end
  end

  assign O_DONE       = r_r.done;
  assign O_TAKEN      = r_r.taken && r_r.done;
  assign O_NEXT_PC    = r_r.npc;
  assign O_CC_WE      = r_r.cc_we;
  assign O_CC         = r_r.cc;
  assign O_CARRY_FLAG = r_r.cflag;
  assign O_CARRY_OUT  = r_r.cout;
  assign O_REG_WE     = r_r.reg_we;
  assign O_REG_WDATA  = r_r.wdata;

  // Condition codes are written only by floating branches.
  a_cc_write_kind: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_CC_WE |-> O_DONE && $past(is_flt)) else $error("cc written by wrong kind");
  // Carry flag is echoed unchanged at completion.
  a_carry_kept: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_DONE |-> O_CARRY_FLAG == $past(I_CARRY_FLAG)) else $error("carry flag changed");
  // Carry-out is echoed unchanged at completion.
  a_cout_kept: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_DONE |-> O_CARRY_OUT == $past(I_CARRY_OUT)) else $error("carry out changed");
  // A claim completes three cycles later.
  a_claim_done: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_CLAIM ##1 I_WORD_VALID |-> ##2 O_DONE) else $error("branch did not complete");
  // Taken branch delivers the captured target.
  a_taken_target: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (r_r.st == CBU_S_TGT && I_WORD_VALID) ##1 take |=> O_TAKEN && O_NEXT_PC == $past(I_WORD, 2))
    else $error("taken target wrong");
  // Register write only for the decrement kind, with the decremented upper half.
  a_hrd_write: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_REG_WE |-> $past(r_r.kind) == CBU_K_HRD
      && O_REG_WDATA[31:16] == $past(I_REG_DATA[31:16]) - 16'h0001)
    else $error("half register write wrong");
  // Decrement branch taken exactly when result is nonzero.
  a_hrd_take: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_REG_WE |-> O_TAKEN == (O_REG_WDATA[31:16] != 16'h0000)) else $error("hrd decision wrong");
  // Carry-clear branch taken only when flag was clear.
  a_cf_clear: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (r_r.st == CBU_S_EXEC && r_r.kind == CBU_K_CF_CL) |=> O_TAKEN == !$past(I_CARRY_FLAG))
    else $error("carry clear decision wrong");
  // Greater-than code branch taken only on positive codes.
  a_cc_gt: assert property (@(posedge I_CLK) disable iff (I_SRST)
    (r_r.st == CBU_S_EXEC && r_r.kind == CBU_K_CC_GT) |=> O_TAKEN == ($past(I_CC) == CBU_CC_POS))
    else $error("cc gt decision wrong");
  // Completion is a single-cycle pulse, so a new claim can follow at once.
  a_done_pulse: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_DONE |=> !O_DONE) else $error("done pulse too long");
  // A floating branch reports zero codes exactly when the selected accumulator was zero.
  a_flt_cc_zero: assert property (@(posedge I_CLK) disable iff (I_SRST)
    O_CC_WE |-> (O_CC == CBU_CC_ZERO) == $past(fzero)) else $error("float codes wrong");
endmodule : cbu_branch_unit
`default_nettype wire

/* File: sim/cbu_proc_model.sv */
// Behavioural model of the processor register file and condition codes.
`timescale 1ns/1ps
`default_nettype none
module cbu_proc_model
  import cbu_pkg::*;
(
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // Register read and write-back from the unit.
  input  wire logic [2:0]       i_sel,
  output logic [31:0]           o_data,
  input  wire logic             i_reg_we,
  input  wire logic [31:0]      i_reg_wdata,
  input  wire logic             i_cc_we,
  input  wire cbu_pkg::cbu_cc_e i_cc,
  output var  cbu_pkg::cbu_cc_e o_cc,
  // Preload and inspection from the bench.
  input  wire logic             i_ld,
  input  wire logic [2:0]       i_ld_sel,
  input  wire logic [31:0]      i_ld_data,
  input  wire cbu_pkg::cbu_cc_e i_ld_cc,
  output logic [31:0]           o_peek
);
  logic [31:0] regs [8];

  // Reads are combinational, so the unit sees the register in its execute cycle.
  assign o_data = regs[i_sel];
  assign o_peek = regs[i_ld_sel];

  // Write-back uses the select that the unit still holds when it completes.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int k = 0; k < 8; k++) begin
        regs[k] <= 32'h0;
      end
      o_cc <= CBU_CC_ZERO;
    end else if (i_ld) begin
      regs[i_ld_sel] <= i_ld_data;
      o_cc           <= i_ld_cc;
    end else begin
      if (i_reg_we) begin
        regs[i_sel] <= i_reg_wdata;
      end
      if (i_cc_we) begin
        o_cc <= i_cc;
      end
    end
  end
endmodule : cbu_proc_model
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench for the conditional branch unit.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cbu_pkg::*;
  logic        clk, srst, wvalid, cflag, cout, f0z, f0n, f1z, f1n, ld;
  logic        claim, done, taken, cc_we, cflag_o, cout_o, reg_we;
  logic [15:0] word, pc, npc;
  logic [2:0]  rsel, ld_sel;
  logic [31:0] rdata, rwdata, ld_data, peek;
  cbu_cc_e     occ, mcc, ld_cc;
  int          n_errors, check_count;
  logic [15:0] cc_ops [6] = '{16'hC381, 16'hC380, 16'hC384, 16'hC383, 16'hC382, 16'hC385};
  logic [7:0]  fl_low [6] = '{8'h51, 8'h50, 8'h54, 8'h53, 8'h52, 8'h55};
  logic [15:0] h_hi [4]   = '{16'h0001, 16'h0005, 16'h0000, 16'h8000};

  cbu_branch_unit u_cbu_branch_unit (
    .I_CLK(clk), .I_SRST(srst), .I_WORD_VALID(wvalid), .I_WORD(word), .I_PC(pc),
    .I_CC(mcc), .I_CARRY_FLAG(cflag), .I_CARRY_OUT(cout), .I_FAC0_ZERO(f0z),
    .I_FAC0_NEG(f0n), .I_FAC1_ZERO(f1z), .I_FAC1_NEG(f1n), .O_REG_SEL(rsel),
    .I_REG_DATA(rdata), .O_CLAIM(claim), .O_DONE(done), .O_TAKEN(taken),
    .O_NEXT_PC(npc), .O_CC_WE(cc_we), .O_CC(occ), .O_CARRY_FLAG(cflag_o),
    .O_CARRY_OUT(cout_o), .O_REG_WE(reg_we), .O_REG_WDATA(rwdata));

  cbu_proc_model u_cbu_proc_model (
    .i_clk(clk), .i_srst(srst), .i_sel(rsel), .o_data(rdata), .i_reg_we(reg_we),
    .i_reg_wdata(rwdata), .i_cc_we(cc_we), .i_cc(occ), .o_cc(mcc), .i_ld(ld),
    .i_ld_sel(ld_sel), .i_ld_data(ld_data), .i_ld_cc(ld_cc), .o_peek(peek));

  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Branch decision for the six relations, state 0 zero, 1 positive, 2 negative.
  function automatic logic take(input int k, input int s);
    case (k)
      0: return s == 1;
      1: return s != 1;
      2: return s == 2;
      3: return s != 0;
      4: return s == 0;
      default: return s != 2;
    endcase
  endfunction : take

  task automatic conclude;
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : cmp

  // Preloads one register and the condition codes through the model.
  task automatic load(input logic [2:0] sel, input logic [31:0] d, input int c);
    @(posedge clk);
    ld      <= 1'b1;
    ld_sel  <= sel;
    ld_data <= d;
    ld_cc   <= cbu_cc_e'(c[1:0]);
    @(posedge clk);
    ld <= 1'b0;
  endtask : load

  // One two-word branch; the done pulse comes exactly one cycle after the target edge.
  task automatic exec(input logic [15:0] op, input logic [15:0] tgt, input logic tk,
                      input logic cwe, input logic rwe);
    @(posedge clk);
    wvalid <= 1'b1;
    word   <= op;
    #1 cmp({31'h0, claim}, 32'h1, "opcode not claimed");
    @(posedge clk);
    word <= tgt;
    @(posedge clk);
    wvalid <= 1'b0;
    word   <= ~tgt;
    @(posedge clk);
    #1 cmp({31'h0, done}, 32'h1, "no completion pulse");
    cmp({31'h0, taken}, {31'h0, tk}, "branch decision");
    cmp({16'h0, npc}, {16'h0, tk ? tgt : pc}, "next pc");
    cmp({30'h0, cflag_o, cout_o}, {30'h0, cflag, cout}, "carry bits moved");
    cmp({30'h0, cc_we, reg_we}, {30'h0, cwe, rwe}, "write enables");
    @(posedge clk);
    #1 cmp({31'h0, done}, 32'h0, "completion longer than one cycle");
  endtask : exec

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    {srst, wvalid, cflag, cout, f0z, f0n, f1z, f1n, ld} = 9'h100;
    word = 16'h0000;
    pc = 16'h2222;
    ld_sel = 3'h0;
    ld_data = 32'h0;
    ld_cc = CBU_CC_ZERO;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 cmp({15'h0, done, npc}, 32'h0, "outputs after reset");
    // Words outside the group are not claimed.
    @(posedge clk);
    wvalid <= 1'b1;
    word   <= 16'h0185;
    #1 cmp({31'h0, claim}, 32'h0, "foreign opcode claimed");
    @(posedge clk);
    word <= 16'hC386;
    #1 cmp({31'h0, claim}, 32'h0, "neighbour opcode claimed");
    @(posedge clk);
    wvalid <= 1'b0;
    // Every condition-code relation against every code; carry bits held odd.
    cflag <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 3; c++) begin
        load(3'h0, 32'h0, c);
        // Targets stay within the current segment.
        exec(cc_ops[k], 16'h4000 + 16'(k * 4 + c), take(k, c), 1'b0, 1'b0);
      end
    end
    // Carry-flag branches with both flag values and the carry-out opposite.
    for (int c = 0; c < 2; c++) begin
      cflag <= c[0];
      cout  <= ~c[0];
      exec(16'hC3C5, 16'h5000 + 16'(c), ~c[0], 1'b0, 1'b0);
      exec(16'hC3C4, 16'h5100 + 16'(c), c[0], 1'b0, 1'b0);
    end
    // Floating branches; the other accumulator always disagrees with the selected one.
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 6; k++) begin
        for (int s = 0; s < 3; s++) begin
          {f0z, f0n} <= (f == 0) ? {s == 0, s == 2} : {s == 2, s == 1};
          {f1z, f1n} <= (f == 1) ? {s == 0, s == 2} : {s == 2, s == 1};
          load(3'h0, 32'h0, (s + 1) % 3);
          exec({7'h10, f[0], fl_low[k]}, 16'h6000 + 16'(s), take(k, s), 1'b1, 1'b0);
          cmp({30'h0, occ}, 32'(s), "floating compare codes");
          cmp({30'h0, mcc}, 32'(s), "codes not written back");
        end
      end
    end
    // Decrement on the upper half, including the one-to-zero and wrap cases.
    for (int r = 0; r < 4; r++) begin
      load(3'(2 * r + 1), {h_hi[r], 16'hA5C3}, 2);
      exec({6'h08, 3'(2 * r + 1), 7'h64}, 16'h7000 + 16'(r), h_hi[r] != 16'h0001, 1'b0, 1'b1);
      cmp({29'h0, rsel}, 32'(2 * r + 1), "register select");
      cmp(rwdata, {h_hi[r] - 16'h0001, 16'hA5C3}, "decremented value");
      cmp(peek, {h_hi[r] - 16'h0001, 16'hA5C3}, "register not written");
      cmp({30'h0, mcc}, 32'h2, "codes changed by decrement");
    end
    conclude();
  end
endmodule : tb
`default_nettype wire
